/* File: design/sfo_otp_ctrl.sv */
// otp mode, lock and write gating of a serial flash command decoder
// assumes serial pins already synchronous to mclk; array lives outside
//
// Our own choices: the APB register port and the register addresses.
`include "sfo_consts.svh"
`default_nettype none

// How it works
// - otp sector is reachable only after the enter-otp opcode
// - in otp mode the otp sector replaces addresses fff000-fff1ff
// - in otp mode the status protect bit reports the lock bit
// - lock set rejects program and erase of the otp sector
// - write-status in otp mode drops its data and sets the lock
// - otp program or erase needs lock clear and protect bits zero
// - in otp mode other sectors read freely, write only while unlocked
// - write-disable leaves otp mode
// - in otp mode only sector erase erases the otp data
// - enter-otp is also taken while quad instruction mode is on
// - writes are inhibited for the power-up delay after reset
// - status reads zero after reset; erased array reads all ones
// - chip erase runs only while all protect bits are zero
module sfo_otp_ctrl #(
    parameter int PUW_CYCLES = `SFO_PUW_CYC
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        arst_n,
    // serial pins
    input  wire logic        sclk,
    input  wire logic        csN,
    input  wire logic [3:0]  sio,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // array side
    output logic             opGrant,
    output logic             opReject,
    output logic      [2:0]  opKind,
    output logic      [23:0] opAddr,
    output logic             opOtp,
    output logic             readOtp,
    // state
    output logic             otpMode,
    output logic      [7:0]  statusByte,
    output logic             writeInhibit
);

    localparam int PW = $clog2(PUW_CYCLES + 1);

    generate
        if (PUW_CYCLES < 1) begin : badPuw
            $error("PUW_CYCLES must be at least one");
        end
    endgenerate

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic [31:0] sfoShift(input logic [31:0] s,
                                             input logic [3:0]  d,
                                             input logic        q);
        sfoShift = q ? {s[27:0], d} : {s[30:0], d[0]};
    endfunction : sfoShift

    function automatic logic inOtp(input logic [23:0] a);
        inOtp = (a >= `SFO_OTP_FIRST) && (a <= `SFO_OTP_LAST);
    endfunction : inOtp

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    sfo_pkg::sfo_frame_type frame_reg, frame_next;
    sfo_pkg::sfo_op_type    decKind;
    logic          sclkPrev_reg;
    logic [5:0]    cnt_reg, cnt_next;
    logic [31:0]   shift_reg, shift_next;
    logic [7:0]    opc_reg, opc_next;
    logic [23:0]   addr_reg, addr_next;
    logic [7:0]    sr_reg, sr_next;
    logic          lock_reg, lock_next;
    logic          otpMode_reg, otpMode_next;
    logic          quad_reg, quad_next;
    logic [PW-1:0] puw_reg, puw_next;
    logic          opGrant_reg, opGrant_next;
    logic          opReject_reg, opReject_next;
    logic [2:0]    opKind_reg, opKind_next;
    logic [23:0]   opAddr_reg, opAddr_next;
    logic          opOtp_reg, opOtp_next;
    logic          readOtp_reg, readOtp_next;
    logic [7:0]    statusByte_reg, statusByte_next;
    logic          inhibit_reg;
    logic          cmdEn_reg, cmdEn_next;
    logic [31:0]   prdata_reg, prdata_next;
    logic          pready_reg, pready_next;
    logic          pslverr_reg, pslverr_next;
    logic          sclkRise, inhibit, wrOk, endFrame, cntOk, decOk;
    logic          bpZero, apbAcc, apbWr;

    assign sclkRise = sclk & ~sclkPrev_reg;
    assign inhibit  = (puw_reg != PW'(PUW_CYCLES));
    assign wrOk     = sr_reg[`SFO_SR_WEL] & ~inhibit;
    assign bpZero   = (sr_reg[`SFO_SR_BLK_HI:`SFO_SR_BLK_LO] == 4'h0);
    assign endFrame = (frame_reg == sfo_pkg::SFO_SHIFT) & csN & cmdEn_reg;

    // ---------------------------------------------------------------
    // command decode
    // ---------------------------------------------------------------
    always_comb begin
        frame_next      = frame_reg;
        cnt_next        = cnt_reg;
        shift_next      = shift_reg;
        opc_next        = opc_reg;
        addr_next       = addr_reg;
        sr_next         = sr_reg;
        lock_next       = lock_reg;
        otpMode_next    = otpMode_reg;
        quad_next       = quad_reg;
        puw_next        = inhibit ? puw_reg + PW'(1) : puw_reg;
        opGrant_next    = 1'b0;
        opReject_next   = 1'b0;
        opKind_next     = opKind_reg;
        opAddr_next     = opAddr_reg;
        opOtp_next      = opOtp_reg;
        readOtp_next    = readOtp_reg;
        decKind         = sfo_pkg::SFO_NONE;
        cntOk           = 1'b0;
        decOk           = 1'b0;
        case (frame_reg)
            sfo_pkg::SFO_IDLE: begin
                if (!csN) begin
                    frame_next = sfo_pkg::SFO_SHIFT;
                    cnt_next   = 6'h00;
                    shift_next = 32'h0000_0000;
                end
            end
            sfo_pkg::SFO_SHIFT: begin
                if (csN) begin
                    frame_next   = sfo_pkg::SFO_IDLE;
                    readOtp_next = 1'b0;
                end else if (sclkRise) begin
                    shift_next = sfoShift(shift_reg, sio, quad_reg);
                    if (cnt_reg < `SFO_CNT_CAP) begin
                        cnt_next = cnt_reg + (quad_reg ? 6'h04 : 6'h01);
                    end
                    if (cnt_next == `SFO_CNT_OPC && cnt_reg != cnt_next) begin
                        opc_next = shift_next[7:0];
                    end
                    if (cnt_next == `SFO_CNT_ADR && cnt_reg != cnt_next) begin
                        addr_next = shift_next[23:0];
                        if (opc_reg == `SFO_OP_READ) begin
                            readOtp_next = otpMode_reg
                                & inOtp(shift_next[23:0]);
                        end
                    end
                end
            end
            default: frame_next = sfo_pkg::SFO_IDLE;
        endcase
        if (endFrame) begin
            case (opc_reg)
                `SFO_OP_WREN: begin
                    if (cnt_reg == `SFO_CNT_OPC && !inhibit) begin
                        sr_next[`SFO_SR_WEL] = 1'b1;
                    end
                end
                `SFO_OP_WDIS: begin
                    if (cnt_reg == `SFO_CNT_OPC) begin
                        sr_next[`SFO_SR_WEL] = 1'b0;
                        otpMode_next = 1'b0;
                    end
                end
                `SFO_OP_OTP: begin
                    if (cnt_reg == `SFO_CNT_OPC) begin
                        otpMode_next = 1'b1;
                    end
                end
                `SFO_OP_QIO: begin
                    if (cnt_reg == `SFO_CNT_OPC) begin
                        quad_next = 1'b1;
                    end
                end
                `SFO_OP_RSTQIO: begin
                    if (cnt_reg == `SFO_CNT_OPC) begin
                        quad_next = 1'b0;
                    end
                end
                `SFO_OP_WSTAT: begin
                    if (cnt_reg == `SFO_CNT_WSR && wrOk) begin
                        if (otpMode_reg) begin
                            lock_next = 1'b1;
                            sr_next[`SFO_SR_WEL] = 1'b0;
                        end else begin
                            sr_next = {shift_reg[7:2], 2'b00};
                        end
                    end
                end
                `SFO_OP_PROG: decKind = sfo_pkg::SFO_PROG;
                `SFO_OP_SECT: decKind = sfo_pkg::SFO_SECT;
                `SFO_OP_BLK: decKind = sfo_pkg::SFO_BLK;
                `SFO_OP_CHIP1, `SFO_OP_CHIP2: decKind = sfo_pkg::SFO_CHIP;
                default: decKind = sfo_pkg::SFO_NONE;
            endcase
            if (decKind == sfo_pkg::SFO_CHIP) begin
                cntOk = (cnt_reg == `SFO_CNT_OPC);
            end else begin
                cntOk = (cnt_reg >= `SFO_CNT_ADR);
            end
            if (decKind != sfo_pkg::SFO_NONE && cntOk && wrOk) begin
                opOtp_next = otpMode_reg & inOtp(addr_reg)
                    & (decKind == sfo_pkg::SFO_PROG
                       || decKind == sfo_pkg::SFO_SECT);
                if (opOtp_next) begin
                    decOk = ~lock_reg & bpZero;
                end else if (decKind == sfo_pkg::SFO_CHIP) begin
                    decOk = bpZero
                        & ~(otpMode_reg & lock_reg);
                end else begin
                    decOk = ~(otpMode_reg & lock_reg);
                end
                opGrant_next  = decOk;
                opReject_next = ~decOk;
                opKind_next   = decKind;
                opAddr_next   = (decKind == sfo_pkg::SFO_CHIP)
                                ? 24'h00_0000 : addr_reg;
                sr_next[`SFO_SR_WEL] = 1'b0;
            end
        end
        statusByte_next = otpMode_reg
            ? {lock_reg, sr_reg[6:0]} : sr_reg;
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            frame_reg      <= sfo_pkg::SFO_IDLE;
            sclkPrev_reg   <= 1'b0;
            cnt_reg        <= 6'h00;
            shift_reg      <= 32'h0000_0000;
            opc_reg        <= 8'h00;
            addr_reg       <= 24'h00_0000;
            sr_reg         <= `SFO_SR_RESET;
            lock_reg       <= 1'b0;
            otpMode_reg    <= 1'b0;
            quad_reg       <= 1'b0;
            puw_reg        <= '0;
            opGrant_reg    <= 1'b0;
            opReject_reg   <= 1'b0;
            opKind_reg     <= 3'h0;
            opAddr_reg     <= 24'h00_0000;
            opOtp_reg      <= 1'b0;
            readOtp_reg    <= 1'b0;
            statusByte_reg <= `SFO_SR_RESET;
            inhibit_reg    <= 1'b1;
        end else begin
            frame_reg      <= frame_next;
            sclkPrev_reg   <= sclk;
            cnt_reg        <= cnt_next;
            shift_reg      <= shift_next;
            opc_reg        <= opc_next;
            addr_reg       <= addr_next;
            sr_reg         <= sr_next;
            lock_reg       <= lock_next;
            otpMode_reg    <= otpMode_next;
            quad_reg       <= quad_next;
            puw_reg        <= puw_next;
            opGrant_reg    <= opGrant_next;
            opReject_reg   <= opReject_next;
            opKind_reg     <= opKind_next;
            opAddr_reg     <= opAddr_next;
            opOtp_reg      <= opOtp_next;
            readOtp_reg    <= readOtp_next;
            statusByte_reg <= statusByte_next;
            inhibit_reg    <= inhibit;
        end
    end

    // ---------------------------------------------------------------
    // apb slave
    // ---------------------------------------------------------------
    assign apbAcc = psel & penable & ~pready_reg;
    assign apbWr  = psel & penable & pready_reg & pwrite;

    always_comb begin
        cmdEn_next   = cmdEn_reg;
        pready_next  = apbAcc;
        prdata_next  = 32'h0000_0000;
        pslverr_next = 1'b0;
        if (apbWr && paddr == `SFO_REG_CTRL) begin
            cmdEn_next = pwdata[0];
        end
        if (apbAcc) begin
            case (paddr)
                `SFO_REG_CTRL: prdata_next = {31'h0000_0000, cmdEn_reg};
                `SFO_REG_STAT: prdata_next = {20'h0_0000, quad_reg,
                    inhibit_reg, lock_reg, otpMode_reg, statusByte_reg};
                `SFO_REG_LASTOP: prdata_next = {4'h0, opOtp_reg,
                    opKind_reg, opAddr_reg};
                default: pslverr_next = 1'b1;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cmdEn_reg   <= `SFO_CTRL_RESET;
            prdata_reg  <= 32'h0000_0000;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            cmdEn_reg   <= cmdEn_next;
            prdata_reg  <= prdata_next;
            pready_reg  <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    assign prdata       = prdata_reg;
    assign pready       = pready_reg;
    assign pslverr      = pslverr_reg;
    assign opGrant      = opGrant_reg;
    assign opReject     = opReject_reg;
    assign opKind       = opKind_reg;
    assign opAddr       = opAddr_reg;
    assign opOtp        = opOtp_reg;
    assign readOtp      = readOtp_reg;
    assign otpMode      = otpMode_reg;
    assign statusByte   = statusByte_reg;
    assign writeInhibit = inhibit_reg;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    otp_enter_a: assert property (@(posedge mclk) disable iff (!arst_n)
        endFrame && opc_reg == `SFO_OP_OTP && cnt_reg == `SFO_CNT_OPC
        |=> otpMode_reg) else $error("otp mode not entered");
    otp_map_a: assert property (@(posedge mclk) disable iff (!arst_n)
        readOtp_reg |-> otpMode_reg && inOtp(addr_reg))
        else $error("otp read outside otp window");
    status_lock_a: assert property (@(posedge mclk) disable iff (!arst_n)
        $past(otpMode_reg) |-> statusByte_reg[`SFO_SR_PROT]
        == $past(lock_reg)) else $error("status does not show lock");
    lock_block_a: assert property (@(posedge mclk) disable iff (!arst_n)
        opGrant_reg && opOtp_reg |-> !$past(lock_reg))
        else $error("otp write granted while locked");
    lock_set_a: assert property (@(posedge mclk) disable iff (!arst_n)
        endFrame && opc_reg == `SFO_OP_WSTAT && cnt_reg == `SFO_CNT_WSR
        && wrOk && otpMode_reg |=> lock_reg
        && sr_reg[7:2] == $past(sr_reg[7:2]))
        else $error("status write in otp mode misbehaved");
    otp_bp_a: assert property (@(posedge mclk) disable iff (!arst_n)
        opGrant_reg && opOtp_reg |-> $past(bpZero))
        else $error("otp write granted with protect bits set");
    other_lock_a: assert property (@(posedge mclk) disable iff (!arst_n)
        opGrant_reg && $past(otpMode_reg) |-> !$past(lock_reg))
        else $error("write granted in locked otp mode");
    otp_exit_a: assert property (@(posedge mclk) disable iff (!arst_n)
        endFrame && opc_reg == `SFO_OP_WDIS && cnt_reg == `SFO_CNT_OPC
        |=> !otpMode_reg) else $error("write disable kept otp mode");
    sect_only_a: assert property (@(posedge mclk) disable iff (!arst_n)
        opOtp_reg && (opGrant_reg || opReject_reg)
        |-> opKind_reg inside {sfo_pkg::SFO_PROG, sfo_pkg::SFO_SECT})
        else $error("otp hit by a non-sector erase");
    quad_enter_a: assert property (@(posedge mclk) disable iff (!arst_n)
        quad_reg && endFrame && opc_reg == `SFO_OP_OTP
        && cnt_reg == `SFO_CNT_OPC |=> otpMode_reg)
        else $error("enter otp refused in quad mode");
    puw_gate_a: assert property (@(posedge mclk) disable iff (!arst_n)
        opGrant_reg || opReject_reg |-> !$past(inhibit))
        else $error("write decoded during power-up delay");
    chip_bp_a: assert property (@(posedge mclk) disable iff (!arst_n)
        opGrant_reg && opKind_reg == sfo_pkg::SFO_CHIP |-> $past(bpZero))
        else $error("chip erase granted while protected");
    frame_end_a: assert property (@(posedge mclk) disable iff (!arst_n)
        $rose(opGrant_reg) |-> $past(csN) && $past(frame_reg)
        == sfo_pkg::SFO_SHIFT) else $error("write acted inside frame");

endmodule : sfo_otp_ctrl

`default_nettype wire

/* File: design/sfo_consts.svh */
// constants of the serial flash otp mode controller
// assumes a 100 MHz mclk and a byte-addressed apb slave
`ifndef SFO_CONSTS_SVH
`define SFO_CONSTS_SVH

// ---------------------------------------------------------------
// opcodes
// ---------------------------------------------------------------
`define SFO_OP_WSTAT  8'h01
`define SFO_OP_PROG   8'h02
`define SFO_OP_READ   8'h03
`define SFO_OP_WDIS   8'h04
`define SFO_OP_RSTAT  8'h05
`define SFO_OP_WREN   8'h06
`define SFO_OP_SECT   8'h20
`define SFO_OP_QIO    8'h38
`define SFO_OP_OTP    8'h3A
`define SFO_OP_CHIP1  8'h60
`define SFO_OP_CHIP2  8'hC7
`define SFO_OP_BLK    8'hD8
`define SFO_OP_RSTQIO 8'hFF

// ---------------------------------------------------------------
// frame bit counts
// ---------------------------------------------------------------
`define SFO_CNT_OPC 6'h08
`define SFO_CNT_WSR 6'h10
`define SFO_CNT_ADR 6'h20
`define SFO_CNT_CAP 6'h28

// ---------------------------------------------------------------
// otp window and status layout
// ---------------------------------------------------------------
`define SFO_OTP_FIRST 24'hFF_F000
`define SFO_OTP_LAST  24'hFF_F1FF
`define SFO_SR_PROT   7
`define SFO_SR_BLK_HI 5
`define SFO_SR_BLK_LO 2
`define SFO_SR_WEL    1
`define SFO_SR_RESET  8'h00

// ---------------------------------------------------------------
// power-up write delay
// ---------------------------------------------------------------
`define SFO_PUW_MS  10
`define SFO_CLK_MHZ 100
`define SFO_PUW_CYC (`SFO_PUW_MS * 1000 * `SFO_CLK_MHZ)

// ---------------------------------------------------------------
// apb map
// ---------------------------------------------------------------
`define SFO_REG_CTRL   8'h00
`define SFO_REG_STAT   8'h04
`define SFO_REG_LASTOP 8'h08
`define SFO_CTRL_RESET 1'h1

`endif

/* File: design/sfo_pkg.sv */
// types of the serial flash otp mode controller
// assumes nothing beyond the compile order
`default_nettype none

package sfo_pkg;

    typedef enum logic [2:0] {
        SFO_NONE = 3'b000,
        SFO_PROG = 3'b001,
        SFO_SECT = 3'b010,
        SFO_BLK  = 3'b011,
        SFO_CHIP = 3'b100
    } sfo_op_type;

    typedef enum logic [0:0] {
        SFO_IDLE  = 1'b0,
        SFO_SHIFT = 1'b1
    } sfo_frame_type;

endpackage : sfo_pkg

`default_nettype wire

/* File: verif/sfo_spi_host.sv */
// spi host model driving the serial pins of the otp controller
// assumes mclk from the bench; mode 0, sclk idles low
`default_nettype none

module sfo_spi_host (
    // clock
    input  wire logic       mclk,
    // serial pins
    output var logic       sclk,
    output var logic       csN,
    output var logic [3:0] sio
);
    timeunit 1ns;
    timeprecision 1ps;

    int half = 2;

    initial begin
        sclk = 1'b0;
        csN  = 1'b1;
        sio  = 4'h0;
    end

    // ---------------------------------------------------------------
    // one frame, msb first, bits left aligned in b
    // ---------------------------------------------------------------
    task automatic frame(input logic [39:0] b, input int n,
                         input logic quad);
        int i;
        @(posedge mclk);
        csN <= 1'b0;
        for (i = 0; i < n; i += (quad ? 4 : 1)) begin
            if (quad)
                sio <= b[39-i -: 4];
            else
                sio <= {~sio[3:1], b[39-i]};
            repeat (half) @(posedge mclk);
            sclk <= 1'b1;
            repeat (half) @(posedge mclk);
            sclk <= 1'b0;
        end
        repeat (half) @(posedge mclk);
        csN <= 1'b1;
        sio <= ~sio;
        repeat (5) @(posedge mclk);
    endtask : frame
endmodule : sfo_spi_host

`default_nettype wire

/* File: verif/tb.sv */
// self-checking bench of the otp mode controller
// assumes sfo_spi_host as the serial host; apb master in this module
`default_nettype none

`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
    nMismatch++; $display("unexpected %s exp %h got %h", nm, e, g); end end

module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        mclk, arst_n, sclk, csN, psel, penable, pwrite;
    logic [3:0]  sio;
    logic [7:0]  paddr, statusByte, nGrant, nRej, nRd;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, opGrant, opReject, opOtp, readOtp;
    logic        otpMode, writeInhibit, quad, er;
    logic [2:0]  opKind;
    logic [23:0] opAddr;
    int          nMismatch, comparisons, cycles;

    sfo_otp_ctrl #(.PUW_CYCLES(400)) uut (
        .mclk(mclk), .arst_n(arst_n), .sclk(sclk), .csN(csN), .sio(sio),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .opGrant(opGrant), .opReject(opReject),
        .opKind(opKind), .opAddr(opAddr), .opOtp(opOtp),
        .readOtp(readOtp), .otpMode(otpMode), .statusByte(statusByte),
        .writeInhibit(writeInhibit));

    sfo_spi_host host (.mclk(mclk), .sclk(sclk), .csN(csN), .sio(sio));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // ---------------------------------------------------------------
    // decision counters and timeout
    // ---------------------------------------------------------------
    always @(posedge mclk) begin
        cycles++;
        if (!arst_n) begin
            {nGrant, nRej, nRd} <= 24'h00_0000;
        end else begin
            nGrant <= nGrant + {7'h00, opGrant};
            nRej   <= nRej + {7'h00, opReject};
            nRd    <= nRd + {7'h00, readOtp};
        end
        if (cycles == 20000) begin
            nMismatch++;
            summarize();
        end
    end

    task automatic summarize;
        if (nMismatch == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : summarize

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic sf(input logic [7:0] op, input logic [31:0] t,
                      input int n);
        host.frame({op, t}, n, quad);
    endtask : sf

    task automatic dec(input logic [7:0] op, input logic [23:0] a,
                       input int n, input logic g, input logic o);
        logic [7:0] g0, r0;
        g0 = nGrant;
        r0 = nRej;
        sf(8'h06, 32'h0, 8);
        sf(op, {a, 8'h00}, n);
        `CHK("grant", g, (nGrant - g0) == 8'h01)
        `CHK("reject", !g, (nRej - r0) == 8'h01)
        `CHK("opAddr", a, opAddr)
        if (g) `CHK("opOtp", o, opOtp)
    endtask : dec

    task automatic rdo(input logic [23:0] a, input logic e);
        logic [7:0] r0;
        r0 = nRd;
        sf(8'h03, {a, 8'h00}, 32);
        `CHK("readOtp", e, nRd != r0)
    endtask : rdo

    task automatic t_inhibit;
        logic [7:0] g0;
        int n;
        `CHK("inhibit", 1'b1, writeInhibit)
        `CHK("status", 8'h00, statusByte)
        g0 = nGrant;
        sf(8'h06, 32'h0, 8);
        sf(8'h20, 32'h0, 32);
        `CHK("grant", g0, nGrant)
        n = 0;
        while (writeInhibit !== 1'b0 && n < 500) begin
            @(posedge mclk);
            n++;
        end
        `CHK("inhibit", 1'b0, writeInhibit)
    endtask : t_inhibit

    task automatic t_apb;
        apb(1'b0, 8'h00, 32'h0);
        `CHK("ctrl", 32'h0000_0001, rd)
        apb(1'b0, 8'h0C, 32'h0);
        `CHK("pslverr", 1'b1, er)
        apb(1'b0, 8'h04, 32'h0);
        `CHK("stat", 32'h0000_0000, rd & 32'hFFFF_FFFD)
        apb(1'b1, 8'h00, 32'h0);
        sf(8'h06, 32'h0, 8);
        sf(8'h3A, 32'h0, 8);
        `CHK("otpMode", 1'b0, otpMode)
        apb(1'b1, 8'h00, 32'h0000_0001);
    endtask : t_apb

    task automatic t_chip;
        sf(8'h06, 32'h0, 8);
        sf(8'h01, 32'h0400_0000, 16);
        `CHK("status", 8'h04, statusByte)
        dec(8'hC7, 24'h0, 8, 1'b0, 1'b0);
        sf(8'h06, 32'h0, 8);
        sf(8'h01, 32'h0, 16);
        dec(8'h60, 24'h0, 8, 1'b1, 1'b0);
        `CHK("opKind", 3'h4, opKind)
    endtask : t_chip

    task automatic t_otp;
        sf(8'h06, 32'h0, 8);
        sf(8'h3A, 32'h0, 8);
        `CHK("otpMode", 1'b1, otpMode)
        rdo(24'hFF_F100, 1'b1);
        rdo(24'hFF_F200, 1'b0);
        dec(8'h20, 24'hFF_F000, 32, 1'b1, 1'b1);
        dec(8'h20, 24'hFF_F1FF, 32, 1'b1, 1'b1);
        dec(8'h20, 24'hFF_F200, 32, 1'b1, 1'b0);
        dec(8'hD8, 24'hFF_F000, 32, 1'b1, 1'b0);
        apb(1'b0, 8'h08, 32'h0);
        `CHK("lastop", 32'h03FF_F000, rd)
        sf(8'h06, 32'h0, 8);
        sf(8'h01, 32'h0, 16);
        `CHK("lock", 1'b1, statusByte[7])
        apb(1'b0, 8'h04, 32'h0);
        `CHK("statLock", 1'b1, rd[9])
        dec(8'h20, 24'hFF_F000, 32, 1'b0, 1'b0);
        dec(8'h02, 24'h00_0100, 32, 1'b0, 1'b0);
        sf(8'h04, 32'h0, 8);
        `CHK("otpMode", 1'b0, otpMode)
        `CHK("protect", 1'b0, statusByte[7])
        rdo(24'hFF_F000, 1'b0);
    endtask : t_otp

    task automatic t_quad;
        host.half = 5;
        sf(8'h38, 32'h0, 8);
        quad = 1'b1;
        sf(8'h06, 32'h0, 8);
        sf(8'h3A, 32'h0, 8);
        `CHK("otpMode", 1'b1, otpMode)
    endtask : t_quad

    initial begin
        {psel, penable, pwrite, quad, er} = 5'h00;
        paddr = 8'h00;
        {pwdata, rd} = 64'h0;
        arst_n = 1'b0;
        repeat (8) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        t_inhibit();
        t_apb();
        t_chip();
        t_otp();
        t_quad();
        summarize();
    end
endmodule : tb

`default_nettype wire
